// File: dv/mpa_mem_model.sv
// mpa_mem_model: async word-wide memory on the external memory bus.
// assumes: strobes last one cycle; 32 words indexed by address bits 5:1.
`timescale 1ns/1ps
module mpa_mem_model (
  input  wire logic        i_mclk,
  input  wire logic [19:1] i_ma,
  input  wire logic        i_rd,
  input  wire logic        i_wr,
  input  wire logic [1:0]  i_ben,
  input  wire logic [15:0] i_wd,
  input  wire logic        i_oe_n,
  output logic      [15:0] o_rd
);
  logic [15:0] mem [0:31];
  logic [15:0] last_q;
  initial begin
    for (int k = 0; k < 32; k++) begin
      mem[k] = 16'ha5c3 ^ 16'(k);
    end
    last_q = 16'h0000;
  end
  // released bus shows the inverse of the last value
  assign o_rd = i_rd ? mem[i_ma[5:1]] : ~last_q;
  always @(posedge i_mclk) begin
    if (i_rd) begin
      last_q <= mem[i_ma[5:1]];
    end
    if (i_wr && !i_oe_n && i_ben[1]) begin
      mem[i_ma[5:1]][15:8] <= i_wd[15:8];
    end
    if (i_wr && !i_oe_n && i_ben[0]) begin
      mem[i_ma[5:1]][7:0] <= i_wd[7:0];
    end
  end
endmodule : mpa_mem_model

// File: dv/test_memory_page_address_unit.sv
// test_memory_page_address_unit: random self-checking bench of mpa_unit.
// assumes: apb zero wait states, memory model mpa_mem_model on the bus.
`timescale 1ns/1ps
module test_memory_page_address_unit;
  logic        i_mclk, i_rstn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, r;
  logic        i_req, i_req_wr, i_req_byte, o_busy, o_rdata_vld, e;
  logic        o_mem_rd, o_mem_wr, o_md_oe_n;
  logic [5:0]  ev;
  logic [3:0]  i_cpr_val;
  logic [1:0]  i_req_kind, o_mem_ben, s_ben;
  logic [15:0] i_req_addr, i_req_wdata, o_rdata, o_md, i_md, s_md, s_rd;
  logic [4:0]  i_req_ir;
  logic [19:1] o_ma, s_ma;
  int          fail_count = 0;
  int          n_checks = 0;
  mpa_unit dut_u (.i_mclk, .i_rstn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .i_instr_done(ev[0]),
    .i_cpr_load(ev[1]), .i_cpr_val, .i_call(ev[2]), .i_ret(ev[3]),
    .i_dps_set(ev[4]), .i_dps_clr(ev[5]), .i_req, .i_req_kind, .i_req_wr,
    .i_req_byte, .i_req_addr, .i_req_ir, .i_req_wdata, .o_busy, .o_rdata,
    .o_rdata_vld, .o_ma, .o_mem_rd, .o_mem_wr, .o_mem_ben, .o_md,
    .o_md_oe_n, .i_md);
  mpa_mem_model mem_u (.i_mclk, .i_ma(o_ma), .i_rd(o_mem_rd),
    .i_wr(o_mem_wr), .i_ben(o_mem_ben), .i_wd(o_md), .i_oe_n(o_md_oe_n),
    .o_rd(i_md));
  initial begin
    i_mclk = 1'b0;
    forever #25 i_mclk = ~i_mclk;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : give_verdict
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge i_mclk);
    penable <= 1'b1;
    do begin
      @(posedge i_mclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic mem(input logic [1:0] k, input logic w, b,
                     input logic [15:0] a, d, input logic [4:0] ir);
    int n;
    @(posedge i_mclk);
    i_req <= 1'b1;
    i_req_kind <= k;
    i_req_wr <= w;
    i_req_byte <= b;
    i_req_addr <= a;
    i_req_wdata <= d;
    i_req_ir <= ir;
    @(posedge i_mclk);
    i_req <= 1'b0;
    for (n = 0; n < 8; n++) begin
      #1;
      if ((o_mem_rd | o_mem_wr) === 1'b1) break;
      @(posedge i_mclk);
    end
    if (n == 8) chk(32'h1, 32'h0);
    chk({o_busy, o_mem_rd, o_mem_wr, o_md_oe_n}, {1'b1, ~w, w, ~w});
    s_ma = o_ma;
    s_ben = o_mem_ben;
    s_md = o_md;
    for (n = 0; n < 8 && !w; n++) begin
      @(posedge i_mclk);
      #1;
      if (o_rdata_vld === 1'b1) break;
    end
    if (!w && n == 8) chk(32'h1, 32'h0);
    s_rd = o_rdata;
  endtask : mem
  task automatic pulse(input int b);
    @(posedge i_mclk);
    ev <= 6'(1 << b);
    @(posedge i_mclk);
    ev <= 6'h00;
  endtask : pulse
  task automatic dpage(input logic [3:0] p);
    mem(mpa_pkg::KIND_DATA, 1'b0, 1'b0, 16'h0042, 16'h0000, 5'h00);
    chk(s_ma[19:16], p);
    chk(s_ma[15:1], 15'h0021);
  endtask : dpage
  function automatic logic [15:0] sw(input logic [15:0] v);
    return {v[7:0], v[15:8]};
  endfunction : sw
  initial begin
    repeat (20000) @(posedge i_mclk);
    fail_count++;
    give_verdict();
  end
  initial begin
    logic [3:0]  cp, dp, up;
    logic [15:0] v, old, a, ub, x;
    logic [4:0]  ir;
    logic        o, b, sel;
    {i_rstn, psel, penable, pwrite, i_req, i_req_wr, i_req_byte} = 7'h00;
    {paddr, pwdata, i_req_kind, i_req_addr, i_req_ir, i_req_wdata} = '0;
    ev = 6'h00;
    i_cpr_val = 4'h0;
    v = 16'($urandom(32'h3383));
    repeat (12) @(posedge i_mclk);
    i_rstn <= 1'b1;
    for (int k = 0; k < 8; k++) begin
      apb(1'b0, 8'(k * 4), 32'h0);
      chk(r, 32'h0);
    end
    apb(1'b0, 8'h20, 32'h0);
    chk(r, 32'h0);
    chk(e, 1'b1);
    $display("test reset done");
    cp = 4'($urandom()) | 4'h1;
    dp = ~cp;
    apb(1'b1, mpa_pkg::OFS_DPR, {28'h0, dp});
    i_cpr_val <= cp;
    pulse(1);
    dpage(4'h0);
    pulse(0);
    dpage(cp);
    apb(1'b1, mpa_pkg::OFS_IBC, 32'h20);
    apb(1'b0, mpa_pkg::OFS_IBC, 32'h0);
    chk(r[5], 1'b1);
    dpage(dp);
    pulse(5);
    dpage(cp);
    pulse(4);
    dpage(dp);
    mem(mpa_pkg::KIND_FETCH, 1'b0, 1'b0, 16'h0042, 16'h0, 5'h0);
    chk(s_ma[19:16], cp);
    pulse(2);
    apb(1'b0, mpa_pkg::OFS_RPH, 32'h0);
    chk(r, {27'h0, 1'b1, cp});
    apb(1'b1, mpa_pkg::OFS_RPH, {27'h0, 1'b0, dp});
    pulse(3);
    apb(1'b0, mpa_pkg::OFS_IBC, 32'h0);
    chk(r[5], 1'b0);
    dpage(dp);
    apb(1'b1, mpa_pkg::OFS_CPR, {28'h0, cp});
    apb(1'b0, mpa_pkg::OFS_STAT, 32'h0);
    chk(r, {26'h0, cp, 2'b10});
    pulse(0);
    dpage(cp);
    i_cpr_val <= dp;
    pulse(1);
    @(posedge i_mclk);
    ev <= 6'h05;
    @(posedge i_mclk);
    ev <= 6'h00;
    dpage(dp);
    apb(1'b0, mpa_pkg::OFS_RPH, 32'h0);
    chk(r, {27'h0, 1'b0, cp});
    pulse(3);
    dpage(cp);
    $display("test pages done");
    for (int i = 0; i < 24; i++) begin
      o = i[2];
      b = i[1];
      apb(1'b1, mpa_pkg::OFS_CFG, {29'h0, o, 2'h0});
      a = 16'($urandom());
      a[0] = i[0];
      v = 16'($urandom()) | 16'h0100;
      sel = o ^ a[0];
      old = mem_u.mem[a[5:1]];
      mem(mpa_pkg::KIND_DATA, 1'b1, b, a, v, 5'h0);
      chk(s_ma[15:1], a[15:1]);
      chk(s_ben, b ? {~sel, sel} : 2'b11);
      chk(s_md, b ? {v[7:0], v[7:0]} : (sel ? sw(v) : v));
      x = sel ? {old[15:8], v[7:0]} : {v[7:0], old[7:0]};
      x = b ? x : (sel ? sw(v) : v);
      mem(mpa_pkg::KIND_DATA, 1'b0, b, a, 16'h0, 5'h0);
      chk(mem_u.mem[a[5:1]], x);
      chk(s_rd, b ? {8'h00, sel ? x[7:0] : x[15:8]} : (sel ? sw(x) : x));
    end
    $display("test byte order done");
    for (int j = 0; j < 6; j++) begin
      up = 4'($urandom());
      ub = 16'($urandom()) & 16'hfffe;
      ir = 5'($urandom());
      if (j == 0) begin
        {up, ub, ir} = {4'h2, 16'h3310, 5'h1f};
      end
      apb(1'b1, mpa_pkg::OFS_UPS, {28'h0, up});
      apb(1'b1, mpa_pkg::OFS_UBB, {16'h0, ub});
      apb(1'b0, mpa_pkg::OFS_UBB, 32'h0);
      chk(r, {16'h0, ub});
      v = 16'($urandom());
      a = 16'($urandom());
      mem(mpa_pkg::KIND_USER, 1'b1, j[0], a, v, ir);
      chk({s_ma, 1'b0}, {up, ub[15:6], ub[5:1] | ir, 1'b0});
      if (j == 0) chk({s_ma, 1'b0}, 20'h2333e);
      chk({s_ben, s_md}, {2'b11, v});
      mem(mpa_pkg::KIND_USER, 1'b0, j[0], a, 16'h0, ir);
      chk(s_rd, v);
    end
    $display("test user space done");
    give_verdict();
  end
endmodule : test_memory_page_address_unit

// File: rtl/mpa_lane.sv
// mpa_lane: byte steering between the data register and a memory word.
// assumes: purely combinational; even byte sits in bits 15:8 of the word unless order is set.
`timescale 1ns/1ps
module mpa_lane (
  input  wire logic        i_byte,
  input  wire logic        i_sel,
  input  wire logic [15:0] i_wdata,
  input  wire logic [15:0] i_rword,
  output logic      [1:0]  o_ben,
  output logic      [15:0] o_wword,
  output logic      [15:0] o_rdata
);
  always_comb begin
    if (i_byte) begin
      o_ben   = i_sel ? 2'h1 : 2'h2;
      o_wword = {i_wdata[7:0], i_wdata[7:0]};
      o_rdata = {8'h00, i_sel ? i_rword[7:0] : i_rword[15:8]};
    end else begin
      o_ben   = 2'h3;
      o_wword = i_sel ? {i_wdata[7:0], i_wdata[15:8]} : i_wdata;
      o_rdata = i_sel ? {i_rword[7:0], i_rword[15:8]} : i_rword;
    end
  end
endmodule : mpa_lane

// File: rtl/mpa_pkg.sv
// mpa_pkg: shared constants of the memory page address unit.
// assumes: included first in compile order; nothing imported.
package mpa_pkg;
  // apb register byte offsets
  localparam logic [7:0] OFS_IBC  = 8'h00;
  localparam logic [7:0] OFS_CFG  = 8'h04;
  localparam logic [7:0] OFS_CPR  = 8'h08;
  localparam logic [7:0] OFS_DPR  = 8'h0c;
  localparam logic [7:0] OFS_RPH  = 8'h10;
  localparam logic [7:0] OFS_UPS  = 8'h14;
  localparam logic [7:0] OFS_UBB  = 8'h18;
  localparam logic [7:0] OFS_STAT = 8'h1c;
  // field positions
  localparam int DPS_BIT   = 5;
  localparam int ORDER_BIT = 2;
  localparam int RPH_DPS   = 4;
  // reset values
  localparam logic [3:0]  CPR_RST = 4'h0;
  localparam logic [3:0]  DPR_RST = 4'h0;
  localparam logic [3:0]  UPS_RST = 4'h0;
  localparam logic [15:0] UBB_RST = 16'h0000;
  localparam logic [4:0]  RPH_RST = 5'h00;
  // access kinds
  localparam logic [1:0] KIND_FETCH = 2'h0;
  localparam logic [1:0] KIND_DATA  = 2'h1;
  localparam logic [1:0] KIND_USER  = 2'h2;
endpackage : mpa_pkg

// File: rtl/mpa_unit.sv
// mpa_unit: page address unit for code, data and user memory spaces.
// assumes: one clock, apb registers, asynchronous word-wide memory.
`timescale 1ns/1ps
module mpa_unit (
  input  wire logic        i_mclk,
  input  wire logic        i_rstn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // instruction sequencing events
  input  wire logic        i_instr_done,
  input  wire logic        i_cpr_load,
  input  wire logic [3:0]  i_cpr_val,
  input  wire logic        i_call,
  input  wire logic        i_ret,
  input  wire logic        i_dps_set,
  input  wire logic        i_dps_clr,
  // memory request
  input  wire logic        i_req,
  input  wire logic [1:0]  i_req_kind,
  input  wire logic        i_req_wr,
  input  wire logic        i_req_byte,
  input  wire logic [15:0] i_req_addr,
  input  wire logic [4:0]  i_req_ir,
  input  wire logic [15:0] i_req_wdata,
  output logic             o_busy,
  output logic [15:0]      o_rdata,
  output logic             o_rdata_vld,
  // external memory bus
  output logic [19:1]      o_ma,
  output logic             o_mem_rd,
  output logic             o_mem_wr,
  output logic [1:0]       o_mem_ben,
  output logic [15:0]      o_md,
  output logic             o_md_oe_n,
  input  wire logic [15:0] i_md
);
  typedef enum logic {MP_IDLE, MP_ACC} mpa_phase_e;

  typedef struct packed {
    mpa_phase_e  phase;
    logic [3:0]  code_page_selector;
    logic [3:0]  cpr_new;
    logic        cpr_pend;
    logic [3:0]  data_page_selector;
    logic        dps;
    logic        order;
    logic [4:0]  rph;
    logic [3:0]  ups;
    logic [15:0] ubb;
    logic [19:1] ma;
    logic        rd;
    logic        wr;
    logic [1:0]  ben;
    logic [15:0] md;
    logic        md_oe_n;
    logic        rbyte;
    logic        rsel;
    logic [15:0] rdata;
    logic        rvld;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } mpa_state_s;

  mpa_state_s s_q;
  mpa_state_s s_d;

  logic        req_byte;
  logic        req_sel;
  logic [3:0]  req_page;
  logic [1:0]  w_ben;
  logic [15:0] w_word;
  logic [15:0] r_data;
  logic        apb_wr;
  logic        apb_setup;

  assign apb_setup = psel & ~penable;
  assign apb_wr    = psel & penable & s_q.pready & pwrite;

  // byte steering only for data space; user and fetch stay whole words
  assign req_byte = (i_req_kind == mpa_pkg::KIND_DATA) & i_req_byte;
  assign req_sel  = (i_req_kind == mpa_pkg::KIND_DATA)
                  & (s_q.order ^ i_req_addr[0]);
  assign req_page = ((i_req_kind == mpa_pkg::KIND_DATA) && s_q.dps)
                  ? s_q.data_page_selector : s_q.code_page_selector;

  mpa_lane u_wlane (
    .i_byte  (req_byte),
    .i_sel   (req_sel),
    .i_wdata (i_req_wdata),
    .i_rword (16'h0000),
    .o_ben   (w_ben),
    .o_wword (w_word),
    .o_rdata ()
  );

  mpa_lane u_rlane (
    .i_byte  (s_q.rbyte),
    .i_sel   (s_q.rsel),
    .i_wdata (16'h0000),
    .i_rword (i_md),
    .o_ben   (),
    .o_wword (),
    .o_rdata (r_data)
  );

  always_comb begin
    s_d         = s_q;
    s_d.rvld    = 1'b0;
    s_d.pready  = apb_setup;
    s_d.pslverr = 1'b0;
    // code page: load is held pending across one instruction
    if (i_instr_done && s_q.cpr_pend) begin
      s_d.code_page_selector      = s_q.cpr_new;
      s_d.cpr_pend = 1'b0;
    end
    if (i_cpr_load) begin
      s_d.cpr_new  = i_cpr_val;
      s_d.cpr_pend = 1'b1;
    end
    // data page select flag, software write lowest priority
    if (apb_wr && paddr == mpa_pkg::OFS_IBC) begin
      s_d.dps = pwdata[mpa_pkg::DPS_BIT];
    end
    if (i_dps_set) begin
      s_d.dps = 1'b1;
    end else if (i_dps_clr) begin
      s_d.dps = 1'b0;
    end
    if (apb_wr && paddr == mpa_pkg::OFS_RPH) begin
      s_d.rph = pwdata[4:0];
    end
    if (i_call) begin
      s_d.rph = {s_q.dps, s_q.code_page_selector};
    end else if (i_ret) begin
      s_d.code_page_selector      = s_q.rph[3:0];
      s_d.cpr_pend = 1'b0;
      s_d.dps      = s_q.rph[mpa_pkg::RPH_DPS];
    end
    if (apb_wr) begin
      case (paddr)
        mpa_pkg::OFS_CFG: s_d.order = pwdata[mpa_pkg::ORDER_BIT];
        mpa_pkg::OFS_CPR: begin
          s_d.cpr_new  = pwdata[3:0];
          s_d.cpr_pend = 1'b1;
        end
        mpa_pkg::OFS_DPR: s_d.data_page_selector = pwdata[3:0];
        mpa_pkg::OFS_UPS: s_d.ups = pwdata[3:0];
        mpa_pkg::OFS_UBB: s_d.ubb = pwdata[15:0];
        default: ;
      endcase
    end
    // register reads answered in the access phase
    if (apb_setup) begin
      s_d.prdata = 32'h0000_0000;
      case (paddr)
        mpa_pkg::OFS_IBC:  s_d.prdata[mpa_pkg::DPS_BIT] = s_q.dps;
        mpa_pkg::OFS_CFG:  s_d.prdata[mpa_pkg::ORDER_BIT] = s_q.order;
        mpa_pkg::OFS_CPR:  s_d.prdata[3:0] = s_q.code_page_selector;
        mpa_pkg::OFS_DPR:  s_d.prdata[3:0] = s_q.data_page_selector;
        mpa_pkg::OFS_RPH:  s_d.prdata[4:0] = s_q.rph;
        mpa_pkg::OFS_UPS:  s_d.prdata[3:0] = s_q.ups;
        mpa_pkg::OFS_UBB:  s_d.prdata[15:0] = s_q.ubb;
        mpa_pkg::OFS_STAT: s_d.prdata[5:0] = {s_q.cpr_new, s_q.cpr_pend,
                                              s_q.phase == MP_ACC};
        default:           s_d.pslverr = 1'b1;
      endcase
    end
    // memory access: one address cycle, read data sampled at its end
    case (s_q.phase)
      MP_IDLE: begin
        if (i_req) begin
          s_d.phase = MP_ACC;
          s_d.rd    = ~i_req_wr;
          s_d.wr    = i_req_wr;
          s_d.ben   = w_ben;
          s_d.rbyte = req_byte;
          s_d.rsel  = req_sel;
          if (i_req_kind == mpa_pkg::KIND_USER) begin
            s_d.ma  = {s_q.ups, s_q.ubb[15:6],
                       s_q.ubb[5:1] | i_req_ir};
          end else begin
            s_d.ma  = {req_page, i_req_addr[15:1]};
          end
          if (i_req_wr) begin
            s_d.md      = w_word;
            s_d.md_oe_n = 1'b0;
          end
        end
      end
      MP_ACC: begin
        s_d.phase   = MP_IDLE;
        s_d.rd      = 1'b0;
        s_d.wr      = 1'b0;
        s_d.md_oe_n = 1'b1;
        if (s_q.rd) begin
          s_d.rdata = r_data;
          s_d.rvld  = 1'b1;
        end
      end
      default: s_d.phase = MP_IDLE;
    endcase
  end

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      s_q          <= '0;
      s_q.phase    <= MP_IDLE;
      s_q.code_page_selector      <= mpa_pkg::CPR_RST;
      s_q.data_page_selector      <= mpa_pkg::DPR_RST;
      s_q.dps      <= 1'b0;
      s_q.rph      <= mpa_pkg::RPH_RST;
      s_q.ups      <= mpa_pkg::UPS_RST;
      s_q.ubb      <= mpa_pkg::UBB_RST;
      s_q.md_oe_n  <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign prdata      = s_q.prdata;
  assign pready      = s_q.pready;
  assign pslverr     = s_q.pslverr;
  assign o_busy      = s_q.phase == MP_ACC;
  assign o_rdata     = s_q.rdata;
  assign o_rdata_vld = s_q.rvld;
  assign o_ma        = s_q.ma;
  assign o_mem_rd    = s_q.rd;
  assign o_mem_wr    = s_q.wr;
  assign o_mem_ben   = s_q.ben;
  assign o_md        = s_q.md;
  assign o_md_oe_n   = s_q.md_oe_n;

  // checks
  property p_call_save;
    @(posedge i_mclk) disable iff (!i_rstn)
    i_call |=> s_q.rph == {$past(s_q.dps), $past(s_q.code_page_selector)};
  endproperty
  a_call_save: assert property (p_call_save)
    else $error("call did not save page and flag");

  property p_ret_restore;
    @(posedge i_mclk) disable iff (!i_rstn)
    (i_ret && !i_call) |=> s_q.dps == $past(s_q.rph[4])
                           && s_q.code_page_selector == $past(s_q.rph[3:0]);
  endproperty
  a_ret_restore: assert property (p_ret_restore)
    else $error("return did not restore flag and page");

  property p_cpr_delay;
    @(posedge i_mclk) disable iff (!i_rstn)
    (i_cpr_load && !i_ret && !(i_instr_done && s_q.cpr_pend))
      |=> $stable(s_q.code_page_selector);
  endproperty
  a_cpr_delay: assert property (p_cpr_delay)
    else $error("code page changed on its load");

  property p_cpr_commit;
    @(posedge i_mclk) disable iff (!i_rstn)
    (s_q.cpr_pend && i_instr_done && !i_ret)
      |=> s_q.code_page_selector == $past(s_q.cpr_new);
  endproperty
  a_cpr_commit: assert property (p_cpr_commit)
    else $error("pending code page not applied");

  property p_data_page;
    @(posedge i_mclk) disable iff (!i_rstn)
    (!o_busy && i_req && i_req_kind == mpa_pkg::KIND_DATA)
      |=> o_ma[19:16] == ($past(s_q.dps) ? $past(s_q.data_page_selector)
                                         : $past(s_q.code_page_selector));
  endproperty
  a_data_page: assert property (p_data_page)
    else $error("wrong data page");

  property p_user_addr;
    @(posedge i_mclk) disable iff (!i_rstn)
    (!o_busy && i_req && i_req_kind == mpa_pkg::KIND_USER)
      |=> o_ma[5:1] == ($past(s_q.ubb[5:1]) | $past(i_req_ir))
          && o_mem_ben == 2'h3;
  endproperty
  a_user_addr: assert property (p_user_addr)
    else $error("user address bits wrong");

  property p_byte_read;
    @(posedge i_mclk) disable iff (!i_rstn)
    (o_mem_rd && s_q.rbyte) |=> o_rdata_vld && o_rdata[15:8] == 8'h00;
  endproperty
  a_byte_read: assert property (p_byte_read)
    else $error("byte read upper bits not cleared");

  property p_dps_set;
    @(posedge i_mclk) disable iff (!i_rstn)
    (i_dps_set && !i_ret) |=> s_q.dps;
  endproperty
  a_dps_set: assert property (p_dps_set)
    else $error("flag not set in one cycle");

  property p_one_cycle;
    @(posedge i_mclk) disable iff (!i_rstn)
    (o_mem_rd || o_mem_wr) |=> !o_mem_rd && !o_mem_wr;
  endproperty
  a_one_cycle: assert property (p_one_cycle)
    else $error("memory strobe held too long");

  property p_byte_lane;
    @(posedge i_mclk) disable iff (!i_rstn)
    (!o_busy && i_req && i_req_kind == mpa_pkg::KIND_DATA && i_req_byte)
      |=> o_mem_ben == ($past(s_q.order ^ i_req_addr[0]) ? 2'h1 : 2'h2);
  endproperty
  a_byte_lane: assert property (p_byte_lane)
    else $error("byte lane not chosen by order and address");

  c_call: cover property (@(posedge i_mclk) disable iff (!i_rstn)
    i_call ##[1:20] i_ret);
  c_long: cover property (@(posedge i_mclk) disable iff (!i_rstn)
    i_cpr_load ##1 i_call);
  c_byte: cover property (@(posedge i_mclk) disable iff (!i_rstn)
    o_mem_wr && s_q.rbyte && s_q.order);
endmodule : mpa_unit
